// >>> src/phsc_ctrl.sv
// stall and flush control for the five-stage instruction pipeline
`timescale 1ns/10ps
// Functional notes
// - target registers read in Decode, loads land at end of Execute; stall to order
// - indirect branch right after its register load: hold later instructions two cycles
// - one unrelated instruction between load and indirect branch: hold one cycle
// - taken jump, call or return adds three nop slots; return target from stack
// - conditional branch right after matching flag update stalls one cycle
// - multiplier compute then multiplier-flag condition stalls two cycles total
// - not-expired branch in Decode, next instruction changes expiry: stall two cycles
// - same expiry dependency on a non-branch stalls one cycle
// - counter change from normal loop-back never stalls not-expired conditions
// - status write, conditional post-modify, same index use: stall two cycles
// - one unrelated instruction around the post-modify: stall one cycle
// - two or more unrelated instructions around the post-modify: no stall
// - flag dependency only between matching units
// - memory access using register loaded one or two instructions back stalls 2/1
module phsc_ctrl #(
    parameter int AGEN_REG_W = phsc_pkg::AGEN_REG_W
) (
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire phsc_pkg::phsc_instr_t f2_instr,
    input  wire phsc_pkg::phsc_follow_t f1_follow,
    input  wire logic                  exe_taken,
    input  wire logic                  exe_return,
    output logic                       fetch_hold_q,
    output phsc_pkg::phsc_instr_t      dec_q,
    output phsc_pkg::phsc_instr_t      addr_q,
    output phsc_pkg::phsc_instr_t      exe_q,
    output logic                       pc_from_stack_q,
    output logic [1:0]                 stall_left_q
);

    // the instruction layout is shared with fetch, so the width is not free per instance
    if (AGEN_REG_W != phsc_pkg::AGEN_REG_W)
    begin : g_bad_width
        $error("phsc_ctrl: AGEN_REG_W must match the shared instruction layout");
    end

    // what the pipeline does on the coming edge
    typedef enum logic [1:0] {
        PHSC_ACT_ADVANCE = 2'b00,
        PHSC_ACT_HOLD    = 2'b01,
        PHSC_ACT_FLUSH   = 2'b10
    } phsc_act_t;

    typedef struct packed {
        phsc_pkg::phsc_instr_t  dec;
        phsc_pkg::phsc_instr_t  addr;
        phsc_pkg::phsc_instr_t  exe;
        phsc_pkg::phsc_instr_t  hist0;   // last instruction issued from Decode
        phsc_pkg::phsc_instr_t  hist1;   // the one before that
        logic [phsc_pkg::CNT_W-1:0] cnt; // stall cycles still owed by Decode
        logic [phsc_pkg::CNT_W-1:0] sq;  // fetched slots still to squash
        logic                   hold;
        logic                   pcs;
    } phsc_state_t;

    phsc_state_t st_q;
    phsc_state_t st_d;

    // producer p loads a register that consumer c uses for address generation
    function automatic logic agen_hit(
        input phsc_pkg::phsc_instr_t p,
        input phsc_pkg::phsc_instr_t c
    );
        logic reg_match;
        reg_match = (p.load_reg == c.idx_reg) || (p.load_reg == c.mod_reg);
        agen_hit  = p.valid && p.agen_load && c.valid && c.addr_gen && reg_match;
    endfunction

    // condition tested by c depends on flags of unit u
    function automatic logic flag_match(input phsc_pkg::phsc_cond_t c,
                                        input phsc_pkg::phsc_unit_t u);
        case (c)
            phsc_pkg::PHSC_COND_ALU: flag_match = (u == phsc_pkg::PHSC_UNIT_ALU);
            phsc_pkg::PHSC_COND_MUL: flag_match = (u == phsc_pkg::PHSC_UNIT_MUL);
            phsc_pkg::PHSC_COND_BTST: flag_match = (u == phsc_pkg::PHSC_UNIT_BTST);
            default:                  flag_match = 1'b0;
        endcase
    endfunction

    // c touches the index register that p post-modifies conditionally
    function automatic logic same_idx(input phsc_pkg::phsc_instr_t p,
                                      input phsc_pkg::phsc_instr_t c);
        same_idx = p.valid && c.valid && (c.addr_gen || c.idx_read) &&
                   (p.idx_reg == c.idx_reg);
    endfunction

    function automatic logic [1:0] max2(input logic [1:0] a, input logic [1:0] b);
        max2 = (a > b) ? a : b;
    endfunction

    // address registers are read in Decode but written at the end of Execute
    function automatic logic [1:0] stall_agen(
        input phsc_pkg::phsc_instr_t n0,
        input phsc_pkg::phsc_instr_t n1,
        input phsc_pkg::phsc_instr_t c
    );
        stall_agen = phsc_pkg::STALL_NONE;
        if (agen_hit(n0, c))
        begin
            stall_agen = phsc_pkg::STALL_ADJ;
        end
        else if (agen_hit(n1, c))
        begin
            stall_agen = phsc_pkg::STALL_GAP;
        end
    endfunction

    // flags are tested in Address but updated at the end of Execute
    function automatic logic [1:0] stall_flag(
        input phsc_pkg::phsc_instr_t n0,
        input phsc_pkg::phsc_instr_t c
    );
        stall_flag = phsc_pkg::STALL_NONE;
        if (c.valid && c.is_branch && n0.valid && flag_match(c.cond, n0.flag_unit))
        begin
            if (c.cond == phsc_pkg::PHSC_COND_MUL)
            begin
                stall_flag = phsc_pkg::STALL_ADJ;
            end
            else
            begin
                stall_flag = phsc_pkg::STALL_GAP;
            end
        end
    endfunction

    // loop-back updates of the counter never count as an expiry change
    function automatic logic [1:0] stall_exp(
        input phsc_pkg::phsc_instr_t  c,
        input phsc_pkg::phsc_follow_t f
    );
        logic dep;
        stall_exp = phsc_pkg::STALL_NONE;
        dep = c.valid && (c.cond == phsc_pkg::PHSC_COND_NOT_EXP) &&
              f.expiry_change && !f.loop_back;
        if (dep)
        begin
            if (c.is_branch)
            begin
                stall_exp = phsc_pkg::STALL_ADJ;
            end
            else
            begin
                stall_exp = phsc_pkg::STALL_GAP;
            end
        end
    endfunction

    // status write, conditional post-modify, reuse of the same index
    function automatic logic [1:0] stall_ctl(
        input phsc_pkg::phsc_instr_t n0,
        input phsc_pkg::phsc_instr_t n1,
        input phsc_pkg::phsc_instr_t n2,
        input phsc_pkg::phsc_instr_t c
    );
        stall_ctl = phsc_pkg::STALL_NONE;
        if (n0.cond_postmod && same_idx(n0, c))
        begin
            if (n1.valid && n1.status_write)
            begin
                stall_ctl = phsc_pkg::STALL_ADJ;
            end
            else if (n2.valid && n2.status_write)
            begin
                stall_ctl = phsc_pkg::STALL_GAP;
            end
        end
        else if (n1.cond_postmod && same_idx(n1, c) && n2.valid && n2.status_write)
        begin
            stall_ctl = phsc_pkg::STALL_GAP;
        end
        // wider spacing leaves the result at zero
    endfunction

    phsc_pkg::phsc_instr_t p0;
    phsc_pkg::phsc_instr_t p1;
    phsc_pkg::phsc_instr_t p2;
    phsc_pkg::phsc_instr_t inc;
    logic [1:0]            need_agen;
    logic [1:0]            need_flag;
    logic [1:0]            need_exp;
    logic [1:0]            need_ctl;
    logic [1:0]            need;
    logic                  kill_in;
    phsc_act_t             act;

    always_comb
    begin
        st_d      = st_q;
        kill_in   = exe_taken || (st_q.sq != '0);
        inc       = kill_in ? phsc_pkg::NOP_INSTR : f2_instr;
        // predecessors of the incoming instruction, nearest first
        p0        = exe_taken ? phsc_pkg::NOP_INSTR : st_q.dec;
        p1        = st_q.hist0;
        p2        = st_q.hist1;
        need_agen = stall_agen(p0, p1, inc);
        need_flag = stall_flag(p0, inc);
        need_exp  = stall_exp(inc, f1_follow);
        need_ctl  = stall_ctl(p0, p1, p2, inc);
        // overlapping causes share their stall cycles rather than adding up
        need      = max2(max2(need_agen, need_flag), max2(need_exp, need_ctl));

        if (exe_taken)
        begin
            act = PHSC_ACT_FLUSH;
        end
        else if (st_q.cnt != '0)
        begin
            act = PHSC_ACT_HOLD;
        end
        else
        begin
            act = PHSC_ACT_ADVANCE;
        end

        // Execute always takes what Address held
        st_d.exe = st_q.addr;
        st_d.pcs = 1'b0;

        case (act)
            PHSC_ACT_FLUSH:
            begin
                // decode slot and the one fetched slot behind it become nops; sq squashes the next fetched slot
                st_d.addr  = phsc_pkg::NOP_INSTR;
                st_d.dec   = phsc_pkg::NOP_INSTR;
                st_d.hist1 = st_q.hist0;
                st_d.hist0 = phsc_pkg::NOP_INSTR;
                st_d.sq    = phsc_pkg::BRANCH_OVH - phsc_pkg::FLUSH_AT_TAKE;
                st_d.cnt   = '0;
                st_d.pcs   = exe_return;
            end
            PHSC_ACT_HOLD:
            begin
                // Decode and fetch hold, a bubble enters Address
                st_d.addr = phsc_pkg::NOP_INSTR;
                st_d.cnt  = st_q.cnt - phsc_pkg::CNT_STEP;
            end
            PHSC_ACT_ADVANCE:
            begin
                st_d.addr  = st_q.dec;
                st_d.hist1 = st_q.hist0;
                st_d.hist0 = st_q.dec;
                st_d.dec   = inc;
                st_d.cnt   = need;
                if (st_q.sq != '0)
                begin
                    st_d.sq = st_q.sq - phsc_pkg::CNT_STEP;
                end
            end
            default:
            begin
                st_d = '0;
            end
        endcase

        st_d.hold = (st_d.cnt != '0);
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign fetch_hold_q    = st_q.hold;
    assign dec_q           = st_q.dec;
    assign addr_q          = st_q.addr;
    assign exe_q           = st_q.exe;
    assign pc_from_stack_q = st_q.pcs;
    assign stall_left_q    = st_q.cnt;

endmodule

// >>> src/phsc_pkg.sv
// shared types and constants for the pipeline hazard stall control block
package phsc_pkg;

    localparam int          AGEN_REG_W  = 5;
    localparam int          CNT_W       = 2;
    localparam logic [1:0]  STALL_ADJ   = 2'h2;  // producer directly ahead
    localparam logic [1:0]  STALL_GAP   = 2'h1;  // one instruction between
    localparam logic [1:0]  STALL_NONE  = 2'h0;
    localparam logic [1:0]  BRANCH_OVH  = 2'h3;  // flushed slots after a taken branch
    localparam logic [1:0]  FLUSH_AT_TAKE = 2'h2;  // slots cleared on the taken edge itself
    localparam logic [1:0]  CNT_STEP    = 2'h1;

    // unit whose flags an instruction updates
    typedef enum logic [1:0] {
        PHSC_UNIT_NONE = 2'b00,
        PHSC_UNIT_ALU  = 2'b01,
        PHSC_UNIT_MUL  = 2'b10,
        PHSC_UNIT_BTST = 2'b11
    } phsc_unit_t;

    // source of the condition an instruction tests
    typedef enum logic [2:0] {
        PHSC_COND_NONE = 3'b000,
        PHSC_COND_ALU  = 3'b001,
        PHSC_COND_MUL  = 3'b010,
        PHSC_COND_BTST    = 3'b011,
        PHSC_COND_NOT_EXP = 3'b100
    } phsc_cond_t;

    // decoded instruction as it travels down the pipe
    typedef struct packed {
        logic                  valid;
        logic                  agen_load;    // loads a data_address_generator register
        logic [AGEN_REG_W-1:0] load_reg;
        logic                  addr_gen;     // memory access or indirect branch target
        logic [AGEN_REG_W-1:0] idx_reg;      // index register used or read
        logic [AGEN_REG_W-1:0] mod_reg;      // modify register used
        logic                  idx_read;     // plain read of idx_reg
        logic                  is_branch;
        phsc_cond_t            cond;
        phsc_unit_t            flag_unit;    // flags this instruction updates
        logic                  status_write; // writes arith_status_x/y or flag regs
        logic                  cond_postmod; // conditional post-modify on idx_reg
    } phsc_instr_t;

    // look-ahead information about the instruction following Decode
    typedef struct packed {
        logic                  expiry_change; // counted_loop_setup, push/pop, abort, counter load
        logic                  loop_back;    // counter change from normal loop-back only
    } phsc_follow_t;

    localparam phsc_instr_t NOP_INSTR = '0;

endpackage

// >>> tb/phsc_ctrl_monitor.sv
// port-level concurrent checks for the pipeline hazard stall control block
`timescale 1ns/10ps
module phsc_ctrl_monitor (
    input wire logic                   core_clk,
    input wire logic                   resetn,
    input wire phsc_pkg::phsc_instr_t  f2_instr,
    input wire phsc_pkg::phsc_follow_t f1_follow,
    input wire logic                   exe_taken,
    input wire logic                   exe_return,
    input wire logic                   fetch_hold_q,
    input wire phsc_pkg::phsc_instr_t  dec_q,
    input wire phsc_pkg::phsc_instr_t  addr_q,
    input wire phsc_pkg::phsc_instr_t  exe_q,
    input wire logic                   pc_from_stack_q,
    input wire logic [1:0]             stall_left_q
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // squashed slots are nops, so a pending squash never satisfies this
    sequence agen_use_s;
        !fetch_hold_q && !exe_taken && dec_q.agen_load && f2_instr.valid && f2_instr.addr_gen
            && (f2_instr.idx_reg == dec_q.load_reg || f2_instr.mod_reg == dec_q.load_reg);
    endsequence
    sequence squash_s;
        dec_q == phsc_pkg::NOP_INSTR && addr_q == phsc_pkg::NOP_INSTR;
    endsequence

    AST_HOLD_MATCH: assert property (fetch_hold_q == (stall_left_q != 2'h0))
        else $error("hold flag disagrees with stall count");
    AST_AGEN_ADJ: assert property (agen_use_s |=> stall_left_q == phsc_pkg::STALL_ADJ)
        else $error("adjacent register load did not stall two cycles");
    AST_COUNT_TWO: assert property (
        stall_left_q == 2'h2 && !exe_taken |=> stall_left_q == 2'h1)
        else $error("stall count did not step down from two");
    AST_COUNT_ONE: assert property (stall_left_q == 2'h1 && !exe_taken |=> !fetch_hold_q)
        else $error("single stall lasted too long");
    AST_BUBBLE: assert property (fetch_hold_q |=> addr_q == phsc_pkg::NOP_INSTR)
        else $error("no bubble entered address stage during hold");
    AST_DEC_HOLD: assert property (fetch_hold_q && !exe_taken |=> $stable(dec_q))
        else $error("decode stage moved during hold");
    AST_SQUASH: assert property (exe_taken |=> squash_s ##1 dec_q == phsc_pkg::NOP_INSTR)
        else $error("taken branch did not flush three slots");
    AST_RET_STACK: assert property (
        1'b1 |=> pc_from_stack_q == ($past(exe_taken) && $past(exe_return)))
        else $error("return target pulse wrong");
    AST_ADDR_FLOW: assert property (
        !fetch_hold_q && !exe_taken |=> addr_q == $past(dec_q))
        else $error("decode did not advance to address stage");
    AST_EXE_FLOW: assert property (1'b1 |=> exe_q == $past(addr_q))
        else $error("execute stage did not take the address stage contents");
endmodule

// >>> tb/phsc_ctrl_tb.sv
// self-checking bench for the pipeline hazard stall control block
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module phsc_ctrl_tb;
    logic                   core_clk = 1'b0;
    logic                   resetn = 1'b0;
    phsc_pkg::phsc_instr_t  f2_instr = phsc_pkg::NOP_INSTR;
    phsc_pkg::phsc_follow_t f1_follow = '0;
    logic                   exe_taken = 1'b0;
    logic                   exe_return = 1'b0;
    logic                   fetch_hold_q;
    phsc_pkg::phsc_instr_t  dec_q;
    phsc_pkg::phsc_instr_t  addr_q;
    phsc_pkg::phsc_instr_t  exe_q;
    logic                   pc_from_stack_q;
    logic [1:0]             stall_left_q;
    logic [1:0]             got;
    int                     miscompares = 0;
    int                     comparisons = 0;
    // five codes oldest first, then {lce_change, loop_back, expected stall}
    logic [23:0]            rows [22] = '{
        24'h00012_2, 24'h00102_1, 24'h0001E_2, 24'h0010E_1, 24'h0100E_0,
        24'h00034_1, 24'h00056_2, 24'h00054_0, 24'h00036_0, 24'h00087_1,
        24'h00037_0, 24'h00084_0, 24'h00009_A, 24'h0000A_9, 24'h00009_C,
        24'h00009_0, 24'h00BCD_2, 24'h00BCF_2, 24'h0B0CD_1, 24'h0BC0D_1,
        24'hB0C0D_0, 24'hBC00D_0};

    phsc_ctrl i_phsc_ctrl (
        .core_clk        (core_clk),
        .resetn          (resetn),
        .f2_instr        (f2_instr),
        .f1_follow       (f1_follow),
        .exe_taken       (exe_taken),
        .exe_return      (exe_return),
        .fetch_hold_q    (fetch_hold_q),
        .dec_q           (dec_q),
        .addr_q          (addr_q),
        .exe_q           (exe_q),
        .pc_from_stack_q (pc_from_stack_q),
        .stall_left_q    (stall_left_q)
    );

    always #25 core_clk = ~core_clk;

    // 0 unrelated, 1 load r8, 2 jump via r8, E access via r8, C/D/F post-modify, use, read of r3
    function automatic phsc_pkg::phsc_instr_t ins(input logic [3:0] k);
        phsc_pkg::phsc_instr_t r;
        r = phsc_pkg::NOP_INSTR;
        r.valid = 1'b1;
        r.agen_load = (k == 4'h1);
        r.load_reg = 5'h08;
        r.addr_gen = (k inside {4'h2, 4'hC, 4'hD, 4'hE});
        r.idx_reg = (k == 4'hE) ? 5'h08 : 5'h03;
        r.mod_reg = (k == 4'h2) ? 5'h08 : 5'h04;
        r.idx_read = (k == 4'hF);
        r.is_branch = (k inside {4'h2, 4'h4, 4'h6, 4'h7, 4'h9});
        r.status_write = (k == 4'hB);
        r.cond_postmod = (k == 4'hC);
        case (k)
            4'h4: r.cond = phsc_pkg::PHSC_COND_ALU;
            4'h6: r.cond = phsc_pkg::PHSC_COND_MUL;
            4'h7: r.cond = phsc_pkg::PHSC_COND_BTST;
            4'h9, 4'hA: r.cond = phsc_pkg::PHSC_COND_NOT_EXP;
            4'h3: r.flag_unit = phsc_pkg::PHSC_UNIT_ALU;
            4'h5: r.flag_unit = phsc_pkg::PHSC_UNIT_MUL;
            4'h8: r.flag_unit = phsc_pkg::PHSC_UNIT_BTST;
            default: r.valid = 1'b1;
        endcase
        return r;
    endfunction

    // offered instruction stays up while held, so the design sees a level
    task automatic issue(input phsc_pkg::phsc_instr_t i, input logic [1:0] f);
        while (fetch_hold_q !== 1'b0) @(negedge core_clk);
        f2_instr = i;
        f1_follow = f;
        @(negedge core_clk);
        got = stall_left_q;
    endtask

    task automatic test_done();
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(negedge core_clk);
        `CHK({fetch_hold_q, stall_left_q, dec_q, exe_q}, '0)
        resetn = 1'b1;
        foreach (rows[n])
        begin
            for (int s = 4; s >= 0; s--)
                issue(ins(rows[n][4*s+4 +: 4]), (s == 0) ? rows[n][3:2] : 2'h0);
            `CHK(got, rows[n][1:0])
        end
        issue(ins(4'h1), 2'h0);
        issue(ins(4'h2), 2'h0);
        exe_taken = 1'b1;
        exe_return = 1'b1;
        @(negedge core_clk);
        `CHK({stall_left_q, pc_from_stack_q}, 3'h1)
        `CHK(dec_q | addr_q, phsc_pkg::NOP_INSTR)
        exe_taken = 1'b0;
        exe_return = 1'b0;
        f2_instr = ins(4'h0);
        @(negedge core_clk);
        `CHK({pc_from_stack_q, dec_q}, '0)
        @(negedge core_clk);
        `CHK(dec_q, ins(4'h0))
        issue(ins(4'h1), 2'h0);
        issue(ins(4'hE), 2'h0);
        resetn = 1'b0;
        @(negedge core_clk);
        `CHK({fetch_hold_q, stall_left_q, dec_q}, '0)
        resetn = 1'b1;
        @(negedge core_clk);
        `CHK({stall_left_q, dec_q}, {2'h0, ins(4'hE)})
        test_done();
    end

    // whole sequence needs roughly 150 cycles
    initial
    begin
        repeat (1000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
endmodule

bind phsc_ctrl phsc_ctrl_monitor i_phsc_ctrl_monitor (
    .core_clk        (core_clk),
    .resetn          (resetn),
    .f2_instr        (f2_instr),
    .f1_follow       (f1_follow),
    .exe_taken       (exe_taken),
    .exe_return      (exe_return),
    .fetch_hold_q    (fetch_hold_q),
    .dec_q           (dec_q),
    .addr_q          (addr_q),
    .exe_q           (exe_q),
    .pc_from_stack_q (pc_from_stack_q),
    .stall_left_q    (stall_left_q)
);
